//--- inc/can_status_pkg.sv
// Shared constants and carriers for the CAN status and bit-timing block
package can_status_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_ENABLES  = 8'h04;
  localparam logic [7:0] OFS_ERR_CNT  = 8'h08;
  localparam logic [7:0] OFS_TIMING_A = 8'h0C;
  localparam logic [7:0] OFS_TIMING_B = 8'h10;
  localparam logic [7:0] OFS_CLK_CTRL = 8'h14;
  // Flag register field positions
  localparam int BIT_TX_BUS_OFF   = 13;
  localparam int BIT_TX_ERR_PASS  = 12;
  localparam int BIT_RX_ERR_PASS  = 11;
  localparam int BIT_TX_WARNING   = 10;
  localparam int BIT_RX_WARNING   = 9;
  localparam int BIT_ANY_WARNING  = 8;
  localparam int BIT_INVALID_MSG  = 7;
  localparam int BIT_WAKEUP       = 6;
  localparam int BIT_ERROR        = 5;
  localparam int BIT_FIFO_AFULL   = 3;
  localparam int BIT_RX_OVERFLOW  = 2;
  localparam int BIT_RX_BUFFER    = 1;
  localparam int BIT_TX_BUFFER    = 0;
  localparam logic [15:0] FLAG_CLEARABLE = 16'h00EF;
  // Timing register A fields
  localparam int SJW_LSB = 6;
  localparam int BRP_LSB = 0;
  // Timing register B fields, then the clock control bit
  localparam int WAKE_FILT_BIT = 14;
  localparam int PH2_LSB       = 8;
  localparam int PH2_SEL_BIT   = 7;
  localparam int TRIPLE_BIT    = 6;
  localparam int PH1_LSB       = 3;
  localparam int PROP_LSB      = 0;
  localparam int CLK_SEL_BIT   = 0;
  // Reset values and write masks
  localparam logic [15:0] RST_ENABLES  = 16'h0000;
  localparam logic [15:0] RST_TIMING_A = 16'h0000;
  localparam logic [15:0] RST_TIMING_B = 16'h0000;
  localparam logic [15:0] MASK_ENABLES = 16'h00EF;
  localparam logic [15:0] MASK_TIMING_A = 16'h00FF;
  localparam logic [15:0] MASK_TIMING_B = 16'h47FF;
  // Error state thresholds and transmit error step
  localparam logic [8:0] WARN_LEVEL    = 9'h060;
  localparam logic [8:0] PASSIVE_LEVEL = 9'h07F;
  localparam logic [8:0] BUS_OFF_LEVEL = 9'h0FF;
  localparam logic [8:0] TX_ERR_STEP   = 9'h008;
  // Information processing time in quanta
  localparam logic [3:0] IPT_QUANTA = 4'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic invalid_msg;
    logic fifo_almost_full;
    logic rx_overflow;
    logic rx_buffer;
    logic tx_buffer;
  } can_events_s;

  typedef struct packed {
    logic tx_err;
    logic tx_ok;
    logic rx_err;
    logic rx_ok;
  } err_update_s;

  typedef struct packed {
    logic tq_tick;
    logic sample_point;
    logic sampled_bit;
    logic bit_end;
  } bit_timing_s;
endpackage : can_status_pkg

//--- design/can_status_timing.sv
// CAN flags, enables, error counters and bit-timing engine behind AXI4-Lite
`timescale 1ns/1ps
module can_status_timing
  import can_status_pkg::*;
#(
  parameter int WAKE_FILT_CYCLES = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire can_events_s events,
  input  wire err_update_s err_update,
  input  wire logic        can_rx,
  output bit_timing_s      timing,
  output logic             flag_request
);

  // Filter length must fit the 8-bit wake counter
  if (WAKE_FILT_CYCLES < 1 || WAKE_FILT_CYCLES > 255) begin : g_bad_filt
    $error("WAKE_FILT_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic        aw_held_r;
  logic [7:0]  aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_fire;
  logic [7:0]  rd_addr_r;
  logic        rd_pend_r;

  logic [15:0] enables_r;
  logic [15:0] timing_a_r;
  logic [15:0] timing_b_r;
  logic        clk_sel_r;
  logic [7:0]  flags_low_r;
  logic [15:0] flag_word;
  logic [15:0] err_word;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_FLAGS) || (a == OFS_ENABLES) || (a == OFS_ERR_CNT) ||
             (a == OFS_TIMING_A) || (a == OFS_TIMING_B) || (a == OFS_CLK_CTRL);
  endfunction : mapped

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    merge = v & m;
  endfunction : merge

  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_arready = !rd_pend_r && !s_axi_rvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_pend_r <= 1'b1;
      rd_addr_r <= s_axi_araddr;
    end else begin
      rd_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_pend_r) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(rd_addr_r) ? RESP_OKAY : RESP_SLVERR;
      case (rd_addr_r)
        OFS_FLAGS:    s_axi_rdata <= {16'h0000, flag_word};
        OFS_ENABLES:  s_axi_rdata <= {16'h0000, enables_r};
        OFS_ERR_CNT:  s_axi_rdata <= {16'h0000, err_word};
        OFS_TIMING_A: s_axi_rdata <= {16'h0000, timing_a_r};
        OFS_TIMING_B: s_axi_rdata <= {16'h0000, timing_b_r};
        OFS_CLK_CTRL: s_axi_rdata <= {31'h0000_0000, clk_sel_r};
        default:      s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enables_r  <= RST_ENABLES;
      timing_a_r <= RST_TIMING_A;
      timing_b_r <= RST_TIMING_B;
      clk_sel_r  <= 1'b0;
    end else if (wr_fire) begin
      // enable bits stored, unused bits forced low
      if (aw_addr_r == OFS_ENABLES) begin
        enables_r <= merge(enables_r, w_data_r, w_strb_r, MASK_ENABLES);
      end
      if (aw_addr_r == OFS_TIMING_A) begin
        timing_a_r <= merge(timing_a_r, w_data_r, w_strb_r, MASK_TIMING_A);
      end
      if (aw_addr_r == OFS_TIMING_B) begin
        timing_b_r <= merge(timing_b_r, w_data_r, w_strb_r, MASK_TIMING_B);
      end
      if (aw_addr_r == OFS_CLK_CTRL && w_strb_r[0]) begin
        clk_sel_r <= w_data_r[CLK_SEL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Error counters and error states
  // ----------------------------------------------------------------
  logic [8:0] tx_cnt_r;
  logic [7:0] rx_cnt_r;
  logic [5:0] state_bits;
  logic [5:0] state_prev_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_cnt_r <= 9'h000;
    end else if (err_update.tx_err && tx_cnt_r <= BUS_OFF_LEVEL) begin
      tx_cnt_r <= tx_cnt_r + TX_ERR_STEP;
    end else if (err_update.tx_ok && tx_cnt_r != 9'h000 && tx_cnt_r <= BUS_OFF_LEVEL) begin
      tx_cnt_r <= tx_cnt_r - 9'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_r <= 8'h00;
    end else if (err_update.rx_err && rx_cnt_r != 8'hFF) begin
      rx_cnt_r <= rx_cnt_r + 8'h01;
    end else if (err_update.rx_ok && rx_cnt_r != 8'h00) begin
      rx_cnt_r <= rx_cnt_r - 8'h01;
    end
  end

  // counters side by side, tx saturates in view once bus-off
  assign err_word = {(tx_cnt_r[8] ? 8'hFF : tx_cnt_r[7:0]), rx_cnt_r};

  always_comb begin
    state_bits[5] = tx_cnt_r > BUS_OFF_LEVEL;
    state_bits[4] = tx_cnt_r > PASSIVE_LEVEL;
    state_bits[3] = {1'b0, rx_cnt_r} > PASSIVE_LEVEL;
    state_bits[2] = tx_cnt_r >= WARN_LEVEL;
    state_bits[1] = {1'b0, rx_cnt_r} >= WARN_LEVEL;
    state_bits[0] = state_bits[2] || state_bits[1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_prev_r <= 6'h00;
    end else begin
      state_prev_r <= state_bits;
    end
  end

  // ----------------------------------------------------------------
  // Bus line sampling and wake-up detection
  // ----------------------------------------------------------------
  logic [2:0] rx_sync_r;
  logic       rx_line_r;
  logic       rx_prev_r;
  logic [7:0] wake_cnt_r;
  logic       wake_hit;
  logic       rx_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync_r <= 3'b111;
      rx_line_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], can_rx};
      if (rx_sync_r[1] == rx_sync_r[2]) begin
        rx_line_r <= rx_sync_r[2];
      end
      rx_prev_r <= rx_line_r;
    end
  end

  assign rx_fall = rx_prev_r && !rx_line_r;

  // filtered path needs a held dominant level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt_r <= 8'h00;
    end else if (rx_line_r) begin
      wake_cnt_r <= 8'h00;
    end else if (wake_cnt_r != 8'hFF) begin
      wake_cnt_r <= wake_cnt_r + 8'h01;
    end
  end

  assign wake_hit = timing_b_r[WAKE_FILT_BIT] ?
                    (wake_cnt_r == 8'(WAKE_FILT_CYCLES - 1)) && !rx_line_r : rx_fall;

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[BIT_INVALID_MSG] = events.invalid_msg;
    flag_set[BIT_WAKEUP]      = wake_hit;
    flag_set[BIT_ERROR]       = |(state_bits & ~state_prev_r);
    flag_set[BIT_FIFO_AFULL]  = events.fifo_almost_full;
    flag_set[BIT_RX_OVERFLOW] = events.rx_overflow;
    flag_set[BIT_RX_BUFFER]   = events.rx_buffer;
    flag_set[BIT_TX_BUFFER]   = events.tx_buffer;
    flag_clr = 8'h00;
    if (wr_fire && aw_addr_r == OFS_FLAGS && w_strb_r[0]) begin
      flag_clr = ~w_data_r[7:0] & FLAG_CLEARABLE[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_low_r <= 8'h00;
    end else begin
      flags_low_r <= ((flags_low_r & ~flag_clr) | flag_set) & FLAG_CLEARABLE[7:0];
    end
  end

  assign flag_word = {2'b00, state_bits, flags_low_r};
  assign flag_request = |(flags_low_r & enables_r[7:0]);

  // ----------------------------------------------------------------
  // Time quantum generator
  // ----------------------------------------------------------------
  logic       fcy_div_r;
  logic       mod_tick;
  logic [6:0] pre_cnt_r;
  logic [6:0] pre_top;
  logic       tq_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fcy_div_r <= 1'b0;
    end else begin
      fcy_div_r <= !fcy_div_r;
    end
  end

  // instruction clock runs at half the oscillator rate
  assign mod_tick = clk_sel_r ? fcy_div_r : 1'b1;
  // quantum lasts two times code plus two module clocks
  assign pre_top  = {timing_a_r[BRP_LSB +: 6], 1'b1};
  assign tq_tick  = mod_tick && (pre_cnt_r == pre_top);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_r <= 7'h00;
    end else if (tq_tick) begin
      pre_cnt_r <= 7'h00;
    end else if (mod_tick) begin
      pre_cnt_r <= pre_cnt_r + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Bit segment sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_e;
  seg_e       seg_r;
  logic [3:0] seg_cnt_r;
  logic [3:0] prop_len;
  logic [3:0] ph1_len;
  logic [3:0] ph2_len;
  logic [3:0] sjw_len;
  logic [3:0] ph1_ext_r;
  logic [2:0] samp_r;
  logic       edge_seen_r;
  logic       bit_val_r;
  logic       at_sample;
  logic       ph2_done;

  assign prop_len = {1'b0, timing_b_r[PROP_LSB +: 3]} + 4'h1;
  assign ph1_len  = {1'b0, timing_b_r[PH1_LSB +: 3]} + 4'h1;
  assign sjw_len  = {2'b00, timing_a_r[SJW_LSB +: 2]} + 4'h1;

  always_comb begin
    if (timing_b_r[PH2_SEL_BIT]) begin
      ph2_len = {1'b0, timing_b_r[PH2_LSB +: 3]} + 4'h1;
    end else begin
      ph2_len = (ph1_len > IPT_QUANTA) ? ph1_len : IPT_QUANTA;
    end
  end

  assign at_sample = tq_tick && seg_r == SEG_PH1 && seg_cnt_r + 4'h1 >= ph1_len + ph1_ext_r;
  // shortening relies on jump width below phase 2 length
  assign ph2_done  = tq_tick && seg_r == SEG_PH2 &&
                     (seg_cnt_r + 4'h1 >= ph2_len ||
                      (edge_seen_r && seg_cnt_r + 4'h1 + sjw_len >= ph2_len));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_seen_r <= 1'b0;
    end else if (tq_tick) begin
      edge_seen_r <= rx_fall;
    end else if (rx_fall) begin
      edge_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_r     <= SEG_SYNC;
      seg_cnt_r <= 4'h0;
      ph1_ext_r <= 4'h0;
    end else if (tq_tick) begin
      case (seg_r)
        SEG_SYNC: begin
          seg_r     <= SEG_PROP;
          seg_cnt_r <= 4'h0;
          ph1_ext_r <= 4'h0;
        end
        SEG_PROP: begin
          // Late edge lengthens phase 1
          if (edge_seen_r) begin
            ph1_ext_r <= sjw_len;
          end
          if (seg_cnt_r + 4'h1 >= prop_len) begin
            seg_r     <= SEG_PH1;
            seg_cnt_r <= 4'h0;
          end else begin
            seg_cnt_r <= seg_cnt_r + 4'h1;
          end
        end
        SEG_PH1: begin
          if (edge_seen_r && ph1_ext_r == 4'h0) begin
            ph1_ext_r <= sjw_len;
          end
          if (at_sample) begin
            seg_r     <= SEG_PH2;
            seg_cnt_r <= 4'h0;
          end else begin
            seg_cnt_r <= seg_cnt_r + 4'h1;
          end
        end
        SEG_PH2: begin
          // Early edge shortens phase 2
          if (ph2_done) begin
            seg_r     <= SEG_SYNC;
            seg_cnt_r <= 4'h0;
          end else begin
            seg_cnt_r <= seg_cnt_r + 4'h1;
          end
        end
        default: begin
          seg_r     <= SEG_SYNC;
          seg_cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // last three quanta up to the sample point, majority vote
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_r    <= 3'b111;
      bit_val_r <= 1'b1;
    end else begin
      if (tq_tick) begin
        samp_r <= {samp_r[1:0], rx_line_r};
      end
      if (at_sample) begin
        if (timing_b_r[TRIPLE_BIT]) begin
          bit_val_r <= (samp_r[1] & samp_r[0]) | (samp_r[1] & rx_line_r) | (samp_r[0] & rx_line_r);
        end else begin
          bit_val_r <= rx_line_r;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing <= '0;
    end else begin
      timing.tq_tick      <= tq_tick;
      timing.sample_point <= at_sample;
      timing.bit_end      <= ph2_done;
      timing.sampled_bit  <= bit_val_r;
    end
  end

endmodule : can_status_timing

//--- tb/can_status_timing_chk.sv
// Port assertions for the CAN status and bit-timing block
`timescale 1ns/1ps
module can_status_timing_chk
  import can_status_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire bit_timing_s timing
);
  // --------------------------------
  // Register bus and timing checks
  // --------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_go;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_go;
    s_axi_arvalid && s_axi_arready;
  endsequence
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_latency_a: assert property (wr_go |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  rd_latency_a: assert property (rd_go |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer late or early");
  wr_unmapped_a: assert property (wr_go and s_axi_awaddr > 8'h14 |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  rd_unmapped_a: assert property (rd_go and s_axi_araddr > 8'h14 |-> ##2 s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  tq_gap_a: assert property (timing.tq_tick |=> !timing.tq_tick)
    else $error("quantum shorter than two clocks");
  seg_apart_a: assert property (timing.sample_point |-> !timing.bit_end)
    else $error("sample point at bit end");
endmodule : can_status_timing_chk

//--- tb/can_bus_node.sv
// Far-side CAN node driving dominant bursts onto the bus line
`timescale 1ns/1ps
module can_bus_node (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [7:0] dom_len,
  output logic            can_rx
);
  logic [7:0] left_r = 8'h00;
  always_ff @(posedge aclk) begin
    if (go) begin
      left_r <= dom_len;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end
  assign can_rx = (left_r == 8'h00);
endmodule : can_bus_node

//--- tb/can_status_timing_tb.sv
// Self-checking bench for the CAN status and bit-timing block
`timescale 1ns/1ps
module can_status_timing_tb;
  import can_status_pkg::*;
  localparam int WFC = 4;
  localparam int TQ  = 8;
  logic        aclk, aresetn, node_go, can_rx, flag_request;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dom_len;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs_v, bs_v;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  can_events_s events;
  err_update_s err_update;
  bit_timing_s timing;
  int          err_total, n_tests, gap_v;
  int          ebit[5] = '{7, 3, 2, 1, 0};

  can_status_timing #(.WAKE_FILT_CYCLES(WFC)) u_can_status_timing (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .events, .err_update, .can_rx, .timing, .flag_request
  );
  can_bus_node u_can_bus_node (.aclk, .go(node_go), .dom_len, .can_rx);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------
  // Tasks
  // ----------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic tmo(input logic t);
    if (t) begin
      err_total++;
      $display("mismatch wait expected done got timeout");
      final_report();
    end
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(negedge aclk);
      ha = s_axi_awready;
      hw = s_axi_wready;
      hb = s_axi_bvalid;
      bs_v = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n >= 99);
    chk($sformatf("bresp %h", a), {30'h0, (a > 8'h14) ? RESP_SLVERR : RESP_OKAY}, {30'h0, bs_v});
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
    logic ha, hb;
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(negedge aclk);
      ha = s_axi_arready;
      hb = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rs_v = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hb) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n >= 99);
    chk($sformatf("rdata %h", a), e, rd_v & m);
    chk($sformatf("rresp %h", a), {30'h0, (a > 8'h14) ? RESP_SLVERR : RESP_OKAY}, {30'h0, rs_v});
  endtask : rdc

  task automatic ev(input can_events_s e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= '0;
  endtask : ev

  task automatic errs(input err_update_s e, input int k);
    @(posedge aclk);
    err_update <= e;
    repeat (k) @(posedge aclk);
    err_update <= '0;
  endtask : errs

  task automatic node(input logic [7:0] l);
    @(posedge aclk);
    dom_len <= l;
    node_go <= 1'b1;
    @(posedge aclk);
    node_go <= 1'b0;
    repeat (20) @(posedge aclk);
  endtask : node

  task automatic gap(input int a, input int e);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (timing[a] !== 1'b1 && n < 4000);
      gap_v = 0;
      do begin
        @(negedge aclk);
        gap_v++;
      end while (timing[a] !== 1'b1 && gap_v < 4000);
    end
    tmo(n >= 4000 || gap_v >= 4000);
    chk("period", e, gap_v);
  endtask : gap

  // ----------
  // Sequence
  // ----------
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, node_go} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, dom_len, events, err_update} = '0;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    n_tests = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0);
    $display("test reset done");
    wr(OFS_ENABLES, 32'hFFFF);
    wr(OFS_TIMING_A, 32'hFFFF);
    wr(OFS_TIMING_B, 32'hFFFF);
    wr(OFS_ERR_CNT, 32'hFFFF);
    wr(8'h18, 32'hFFFF);
    rdc(OFS_ENABLES, 32'h00EF);
    rdc(OFS_TIMING_A, 32'h00FF);
    rdc(OFS_TIMING_B, 32'h47FF);
    rdc(OFS_ERR_CNT, 32'h0);
    $display("test access done");
    for (int i = 0; i < 5; i++) begin
      ev(can_events_s'(5'h10 >> i));
      rdc(OFS_FLAGS, 32'h1 << ebit[i]);
      chk("flag_request", 32'h1, {31'h0, flag_request});
      wr(OFS_FLAGS, 32'hFFFF);
      rdc(OFS_FLAGS, 32'h1 << ebit[i]);
      wr(OFS_FLAGS, 32'h0);
      rdc(OFS_FLAGS, 32'h0);
    end
    $display("test flags done");
    node(8'(WFC / 2));
    rdc(OFS_FLAGS, 32'h0);
    node(8'(2 * WFC));
    rdc(OFS_FLAGS, 32'h0040);
    wr(OFS_ENABLES, 32'h0);
    chk("flag_request", 32'h0, {31'h0, flag_request});
    wr(OFS_ENABLES, 32'hFFFF);
    wr(OFS_FLAGS, 32'h0);
    wr(OFS_TIMING_B, 32'h3FFF);
    node(8'(WFC / 2));
    rdc(OFS_FLAGS, 32'h0040);
    wr(OFS_FLAGS, 32'h0);
    $display("test wake done");
    errs(4'b1000, 12);
    rdc(OFS_FLAGS, 32'h0520);
    rdc(OFS_ERR_CNT, 32'h6000);
    errs(4'b0010, 128);
    rdc(OFS_FLAGS, 32'h0F20);
    errs(4'b1000, 5);
    rdc(OFS_FLAGS, 32'h1F20);
    rdc(OFS_ERR_CNT, 32'h8880);
    wr(OFS_FLAGS, 32'h0);
    rdc(OFS_FLAGS, 32'h1F00);
    errs(4'b0001, 1);
    rdc(OFS_FLAGS, 32'h1700);
    rdc(OFS_ERR_CNT, 32'h887F);
    errs(4'b1000, 15);
    rdc(OFS_ERR_CNT, 32'hFF7F);
    rdc(OFS_FLAGS, 32'h2020, 32'h2020);
    $display("test counters done");
    wr(OFS_TIMING_A, 32'h0003);
    gap(3, TQ);
    wr(OFS_TIMING_B, 32'h0288);
    gap(0, 7 * TQ);
    wr(OFS_TIMING_B, 32'h0010);
    gap(0, 8 * TQ);
    wr(OFS_TIMING_B, 32'h0000);
    gap(0, 5 * TQ);
    wr(OFS_CLK_CTRL, 32'h0001);
    gap(3, 2 * TQ);
    wr(OFS_TIMING_B, 32'h0040);
    chk("sampled_bit", 32'h1, {31'h0, timing.sampled_bit});
    node(8'hFF);
    repeat (2) begin
      gap_v = 0;
      do begin
        @(negedge aclk);
        gap_v++;
      end while (timing.sample_point !== 1'b1 && gap_v < 400);
    end
    @(negedge aclk);
    tmo(gap_v >= 400);
    chk("sampled_bit", 32'h0, {31'h0, timing.sampled_bit});
    $display("test timing done");
    final_report();
  end
endmodule : can_status_timing_tb

bind can_status_timing can_status_timing_chk u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timing
);
